// File: rtl/sector_protect_consts.svh
// named constants for the sector protection and lockdown command block
`ifndef SECTOR_PROTECT_CONSTS_SVH
`define SECTOR_PROTECT_CONSTS_SVH

// ****************************************************************
// opcodes
// ****************************************************************
`define OP_PREFIX_1     8'h3d
`define OP_PREFIX_2     8'h2a
`define OP_PREFIX_3     8'h7f
`define OP_PROG_PROT    8'hfc
`define OP_ERASE_PROT   8'hcf
`define OP_LOCKDOWN     8'h30
`define OP_READ_PROT    8'h32

// ****************************************************************
// register layout
// ****************************************************************
`define SECTOR_COUNT    16
`define MAP_WIDTH       128
`define BYTE_SET        8'hff
`define BYTE_CLEAR      8'h00
`define SUB0_LOW_MASK   8'hc0
`define SUB0_HIGH_MASK  8'h30
`define SUB0_LOW_BIT    7
`define SUB0_HIGH_BIT   5
`define SUB0_PAGE_LIMIT 8'h08
`define PROT_RESET      128'h0
`define LOCK_RESET      128'h0

// ****************************************************************
// address decode (binary page addressing)
// ****************************************************************
`define SECTOR_LSB      17
`define PAGE_LSB        9
`define LAST_ADDR_BYTE  2'h2
`define LAST_DUMMY_BYTE 2'h2
`define LAST_BIT        3'h7
`define FULL_BYTE       4'h8
`define FIRST_READ_IDX  5'h01
`define TIMER_DONE      32'h00000001

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS   4
`define T_PROG_NS       5000000
`define T_ERASE_NS      5000000

`endif

// File: rtl/sector_protect_pkg.sv
// types shared by the sector protection and lockdown command block
package sector_protect_pkg;

  typedef enum logic [3:0] {
    S_IDLE, S_PFX2, S_PFX3, S_PFX4, S_PROG_DATA, S_ERASE_ARM,
    S_LOCK_ADDR, S_LOCK_ARM, S_READ_DUMMY, S_READ_DATA, S_IGNORE
  } cmd_state_t;

  typedef enum logic [1:0] {
    OP_NONE, OP_PROGRAM, OP_ERASE, OP_LOCK
  } nv_op_t;

  // events seen on the serial pins, all on clk_sys
  typedef struct packed {
    logic       cs_active;
    logic       cs_rise;
    logic       sck_fall;
    logic       byte_valid;
    logic [7:0] rx_byte;
  } pin_evt_t;

  typedef struct packed {
    logic       cs_s1;
    logic       cs_s2;
    logic       cs_d;
    logic       sck_s1;
    logic       sck_s2;
    logic       sck_d;
    logic       si_s1;
    logic       si_s2;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    pin_evt_t   evt;
  } front_t;

  typedef struct packed {
    cmd_state_t   st;
    logic [3:0]   ptr;
    logic [1:0]   cnt;
    logic [23:0]  addr;
    nv_op_t       op;
    logic         busy;
    logic [31:0]  timer;
    logic [127:0] stage;
    logic [127:0] prot;
    logic [127:0] lock;
    logic [7:0]   tx;
    logic [3:0]   bitn;
    logic [4:0]   rd_idx;
    logic         so;
    logic         so_oe;
    logic         buf1_used;
  } core_t;

endpackage : sector_protect_pkg

// File: rtl/spi_pin_front.sv
// serial pin synchroniser, edge detector and byte assembler
`include "sector_protect_consts.svh"

module spi_pin_front
  import sector_protect_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_sync_b,
  // serial pins
  input  wire logic cs_b,
  input  wire logic sck,
  input  wire logic si,
  // decoded events
  output pin_evt_t  evt
);

  front_t state_ff;
  front_t nxt_state;

  // ****************************************************************
  // edge and byte logic
  // ****************************************************************
  // only the second stage of each synchroniser feeds the logic
  always_comb begin
    nxt_state                = state_ff;
    nxt_state.cs_s1          = ~cs_b;
    nxt_state.cs_s2          = state_ff.cs_s1;
    nxt_state.cs_d           = state_ff.cs_s2;
    nxt_state.sck_s1         = sck;
    nxt_state.sck_s2         = state_ff.sck_s1;
    nxt_state.sck_d          = state_ff.sck_s2;
    nxt_state.si_s1          = si;
    nxt_state.si_s2          = state_ff.si_s1;
    nxt_state.evt.cs_active  = state_ff.cs_s2;
    nxt_state.evt.cs_rise    = state_ff.cs_d & ~state_ff.cs_s2;
    nxt_state.evt.sck_fall   = state_ff.cs_s2 & state_ff.sck_d & ~state_ff.sck_s2;
    nxt_state.evt.byte_valid = 1'b0;
    if (!state_ff.cs_s2) begin
      nxt_state.bit_cnt = '0;
    end else if (state_ff.sck_s2 && !state_ff.sck_d) begin
      nxt_state.shift   = {state_ff.shift[6:0], state_ff.si_s2};
      nxt_state.bit_cnt = state_ff.bit_cnt + 3'h1;
      if (state_ff.bit_cnt == `LAST_BIT) begin
        nxt_state.evt.byte_valid = 1'b1;
        nxt_state.evt.rx_byte    = {state_ff.shift[6:0], state_ff.si_s2};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign evt = state_ff.evt;

endmodule : spi_pin_front

// File: rtl/sector_protect_lockdown_cmds.sv
// command logic for the protection register and the permanent sector lockdown
`include "sector_protect_consts.svh"

// Contract
// - prefix 3D 2A 7F FC starts programming the protection register
// - first data byte goes to sector 0, last to sector 15
// - chip select rise starts the timed program, busy shows meanwhile
// - bytes not received leave their sectors' protection unguaranteed
// - byte pointer wraps, seventeenth byte lands at location 0
// - reprogramming is accepted with global protection on or off
// - programming uses buffer 1 and destroys its old contents
// - opcode 32 plus three dummy bytes reads the protection register
// - sixteen bytes shift out sector 0 first, beyond is undefined
// - chip select rise ends the read and floats the output
// - prefix 3D 2A 7F 30 is the permanent lockdown command
// - three address bytes select the containing sector, any offset
// - chip select rise starts timed lockdown, busy shows meanwhile
// - a locked sector rejects erase and program forever; here reset clears lock_map to zero
// - sixteen lockdown bytes, sectors 1 to 15 read FF or 00
// - sector 0 lockdown uses bits 7:6 and 5:4, low bits zero
// - protection byte FF means protected, 00 means unprotected
// - prefix 3D 2A 7F CF then chip select rise erases the register
module sector_protect_lockdown_cmds
  import sector_protect_pkg::*;
#(
  parameter int T_PROG_NS   = `T_PROG_NS,
  parameter int T_ERASE_NS  = `T_ERASE_NS,
  parameter int PROG_CYCLES = T_PROG_NS / `CLK_PERIOD_NS,
  parameter int ERASE_CYCLES = T_ERASE_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  // serial pins
  input  wire logic         cs_b,
  input  wire logic         sck,
  input  wire logic         si,
  output logic              so_o,
  output logic              so_oe,
  // status and neighbouring blocks
  output logic              busy,
  output logic              buf1_clobber,
  input  wire logic         prot_enable,
  input  wire logic [23:0]  op_addr,
  output logic              op_locked,
  output logic              op_blocked,
  output logic [127:0]      protect_map,
  output logic [127:0]      lock_map
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_s1_ff;
  logic rst_sync_b;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_ff  <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_s1_ff  <= 1'b1;
      rst_sync_b <= rst_s1_ff;
    end
  end

  // ****************************************************************
  // pin front end
  // ****************************************************************
  pin_evt_t evt;

  spi_pin_front u_front (
    .clk_sys    (clk_sys),
    .rst_sync_b (rst_sync_b),
    .cs_b       (cs_b),
    .sck        (sck),
    .si         (si),
    .evt        (evt)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] get_byte(input logic [127:0] map, input logic [3:0] idx);
    get_byte = map[{idx, 3'h0} +: 8];
  endfunction : get_byte

  function automatic logic [127:0] set_byte(input logic [127:0] map, input logic [3:0] idx,
                                            input logic [7:0] val);
    set_byte = map;
    set_byte[{idx, 3'h0} +: 8] = val;
  endfunction : set_byte

  // any address inside a sector selects the whole sector
  function automatic logic [3:0] sector_of(input logic [23:0] a);
    sector_of = a[`SECTOR_LSB +: 4];
  endfunction : sector_of

  function automatic logic low_sub0(input logic [23:0] a);
    low_sub0 = (a[`PAGE_LSB +: 8] < `SUB0_PAGE_LIMIT);
  endfunction : low_sub0

  // flag of the region holding an address; sector 0 is split in two parts
  function automatic logic region_flag(input logic [127:0] map, input logic [23:0] a);
    logic [7:0] b;
    b = get_byte(map, sector_of(a));
    if (sector_of(a) != 4'h0) begin
      region_flag = b[`SUB0_LOW_BIT];
    end else if (low_sub0(a)) begin
      region_flag = b[`SUB0_LOW_BIT];
    end else begin
      region_flag = b[`SUB0_HIGH_BIT];
    end
  endfunction : region_flag

  // ****************************************************************
  // command engine
  // ****************************************************************
  core_t state_ff;
  core_t nxt_state;

  always_comb begin
    logic [3:0] sec;
    logic [7:0] mask;
    logic [7:0] nb;
    nb   = `BYTE_CLEAR;
    sec  = sector_of(state_ff.addr);
    mask = `BYTE_SET;
    if (sec == 4'h0) begin
      mask = low_sub0(state_ff.addr) ? `SUB0_LOW_MASK : `SUB0_HIGH_MASK;
    end
    nxt_state           = state_ff;
    nxt_state.buf1_used = 1'b0;

    // self-timed cycle and its commit
    if (state_ff.busy) begin
      nxt_state.timer = state_ff.timer - 32'h1;
      if (state_ff.timer == `TIMER_DONE) begin
        nxt_state.busy = 1'b0;
        nxt_state.op   = OP_NONE;
        unique case (state_ff.op)
          // programming can only clear erased bits, as in the cell array
          OP_PROGRAM: nxt_state.prot = state_ff.prot & state_ff.stage;
          OP_ERASE:   nxt_state.prot = {`SECTOR_COUNT{`BYTE_SET}};
          // lockdown only ever sets bits, only reset clears them
          OP_LOCK:    nxt_state.lock = set_byte(state_ff.lock, sec,
                                                get_byte(state_ff.lock, sec) | mask);
          OP_NONE:    nxt_state.busy = 1'b0;
        endcase
      end
    end

    // chip select rise launches the armed cycle
    if (evt.cs_rise && !state_ff.busy) begin
      unique case (state_ff.st)
        S_PROG_DATA: begin
          nxt_state.busy  = 1'b1;
          nxt_state.op    = OP_PROGRAM;
          nxt_state.timer = 32'(PROG_CYCLES);
        end
        S_ERASE_ARM: begin
          nxt_state.busy  = 1'b1;
          nxt_state.op    = OP_ERASE;
          nxt_state.timer = 32'(ERASE_CYCLES);
        end
        S_LOCK_ARM: begin
          nxt_state.busy  = 1'b1;
          nxt_state.op    = OP_LOCK;
          nxt_state.timer = 32'(PROG_CYCLES);
        end
        default: nxt_state.busy = state_ff.busy;
      endcase
    end

    if (!evt.cs_active) begin
      nxt_state.st    = S_IDLE;
      nxt_state.so_oe = 1'b0;
      nxt_state.cnt   = '0;
    end else if (evt.byte_valid) begin
      unique case (state_ff.st)
        S_IDLE: begin
          if (evt.rx_byte == `OP_PREFIX_1) begin
            nxt_state.st = state_ff.busy ? S_IGNORE : S_PFX2;
          end else if (evt.rx_byte == `OP_READ_PROT) begin
            nxt_state.st  = S_READ_DUMMY;
            nxt_state.cnt = '0;
          end else begin
            nxt_state.st = S_IGNORE;
          end
        end
        S_PFX2: nxt_state.st = (evt.rx_byte == `OP_PREFIX_2) ? S_PFX3 : S_IGNORE;
        S_PFX3: nxt_state.st = (evt.rx_byte == `OP_PREFIX_3) ? S_PFX4 : S_IGNORE;
        S_PFX4: begin
          if (evt.rx_byte == `OP_PROG_PROT) begin
            // buffer 1 is taken over as the staging store
            nxt_state.st        = S_PROG_DATA;
            nxt_state.ptr       = '0;
            nxt_state.stage     = {`SECTOR_COUNT{`BYTE_SET}};
            nxt_state.buf1_used = 1'b1;
          end else if (evt.rx_byte == `OP_ERASE_PROT) begin
            nxt_state.st = S_ERASE_ARM;
          end else if (evt.rx_byte == `OP_LOCKDOWN) begin
            nxt_state.st  = S_LOCK_ADDR;
            nxt_state.cnt = '0;
          end else begin
            nxt_state.st = S_IGNORE;
          end
        end
        S_PROG_DATA: begin
          nxt_state.stage = set_byte(state_ff.stage, state_ff.ptr, evt.rx_byte);
          nxt_state.ptr   = state_ff.ptr + 4'h1;
        end
        S_LOCK_ADDR: begin
          nxt_state.addr = {state_ff.addr[15:0], evt.rx_byte};
          nxt_state.cnt  = state_ff.cnt + 2'h1;
          if (state_ff.cnt == `LAST_ADDR_BYTE) begin
            nxt_state.st = S_LOCK_ARM;
          end
        end
        // trailing bytes after an erase or lockdown cancel it
        S_ERASE_ARM, S_LOCK_ARM: nxt_state.st = S_IGNORE;
        S_READ_DUMMY: begin
          nxt_state.cnt = state_ff.cnt + 2'h1;
          if (state_ff.cnt == `LAST_DUMMY_BYTE) begin
            nxt_state.st     = S_READ_DATA;
            nxt_state.tx     = get_byte(state_ff.prot, 4'h0);
            nxt_state.bitn   = '0;
            nxt_state.rd_idx = `FIRST_READ_IDX;
            nxt_state.so_oe  = 1'b1;
          end
        end
        S_READ_DATA, S_IGNORE: nxt_state.st = state_ff.st;
      endcase
    end else if (evt.sck_fall && state_ff.st == S_READ_DATA) begin
      // data changes on the falling edge so the host samples it on the rise
      if (state_ff.bitn == `FULL_BYTE) begin
        nb = (state_ff.rd_idx[4]) ? `BYTE_CLEAR
                                  : get_byte(state_ff.prot, state_ff.rd_idx[3:0]);
        nxt_state.so     = nb[7];
        nxt_state.tx     = {nb[6:0], 1'b0};
        nxt_state.bitn   = 4'h1;
        nxt_state.rd_idx = state_ff.rd_idx[4] ? state_ff.rd_idx : state_ff.rd_idx + 5'h1;
      end else begin
        nxt_state.so   = state_ff.tx[7];
        nxt_state.tx   = {state_ff.tx[6:0], 1'b0};
        nxt_state.bitn = state_ff.bitn + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_ff      <= '0;
      state_ff.st   <= S_IDLE;
      state_ff.op   <= OP_NONE;
      state_ff.prot <= `PROT_RESET;
      state_ff.lock <= `LOCK_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign so_o         = state_ff.so;
  assign so_oe        = state_ff.so_oe;
  assign busy         = state_ff.busy;
  assign buf1_clobber = state_ff.buf1_used;
  assign protect_map  = state_ff.prot;
  assign lock_map     = state_ff.lock;
  // a locked region blocks whatever global protection says
  assign op_locked    = region_flag(state_ff.lock, op_addr);
  assign op_blocked   = op_locked | (prot_enable & region_flag(state_ff.prot, op_addr));

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_b);

  prog_start_a: assert property (
    evt.cs_rise && state_ff.st == S_PROG_DATA && !state_ff.busy
    |=> state_ff.busy && state_ff.op == OP_PROGRAM [*2])
    else $error("program cycle did not start on chip select rise");

  ptr_wrap_a: assert property (
    evt.cs_active && evt.byte_valid && state_ff.st == S_PROG_DATA && state_ff.ptr == 4'hf
    |=> state_ff.ptr == 4'h0)
    else $error("protection byte pointer did not wrap");

  first_byte_a: assert property (
    evt.cs_active && evt.byte_valid && state_ff.st == S_PROG_DATA && state_ff.ptr == 4'h0
    |=> state_ff.stage[7:0] == $past(evt.rx_byte))
    else $error("first data byte not stored for sector 0");

  busy_reject_a: assert property (
    evt.cs_active && evt.byte_valid && state_ff.st == S_IDLE && state_ff.busy
    && evt.rx_byte == `OP_PREFIX_1 |=> state_ff.st == S_IGNORE)
    else $error("prefix accepted while busy");

  lock_sticky_a: assert property (
    ($past(state_ff.lock) & ~state_ff.lock) == '0)
    else $error("a lockdown bit was cleared");

  read_float_a: assert property (
    !evt.cs_active |=> !so_oe)
    else $error("serial output driven after chip select rise");

  erase_done_a: assert property (
    state_ff.busy && state_ff.op == OP_ERASE && state_ff.timer == `TIMER_DONE
    |=> !busy && protect_map == {`SECTOR_COUNT{`BYTE_SET}})
    else $error("erase did not set all protection bytes");

  bad_prefix_a: assert property (
    evt.cs_active && evt.byte_valid && state_ff.st == S_PFX4
    && !(evt.rx_byte inside {`OP_PROG_PROT, `OP_ERASE_PROT, `OP_LOCKDOWN})
    |=> state_ff.st == S_IGNORE ##1 !state_ff.busy || $past(state_ff.busy))
    else $error("mismatched prefix was acted on");

  read_first_a: assert property (
    evt.cs_active && evt.byte_valid && state_ff.st == S_READ_DUMMY
    && state_ff.cnt == `LAST_DUMMY_BYTE
    |=> so_oe && state_ff.tx == protect_map[7:0])
    else $error("read did not present sector 0 byte");

  sub0_lock_a: assert property (
    (lock_map[3:0] == 4'h0) && (lock_map[7:6] != 2'h1) && (lock_map[7:6] != 2'h2))
    else $error("sector 0 lockdown byte has an illegal form");

endmodule : sector_protect_lockdown_cmds

// File: test/spi_host_model.sv
// host serial controller model: chip select, clock, data out, data in
module spi_host_model (
  // clock
  input  wire logic clk_sys,
  // serial pins
  output logic      cs_b,
  output logic      sck,
  output logic      si,
  input  wire logic so_o,
  input  wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // sck phases well above the pin synchroniser delay of the block
  localparam int HALF = 8;

  initial begin
    cs_b = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // ********
  // frame tasks
  // ********
  // the gap before the fall keeps commands apart
  task automatic select();
    repeat (2 * HALF) @(negedge clk_sys);
    cs_b = 1'b0;
    repeat (HALF) @(negedge clk_sys);
  endtask : select

  // mode 0, msb first; so_o is taken just before each rising sck
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      repeat (HALF) @(negedge clk_sys);
      // a floated line reads as the inverse so an early release shows up
      rx[i] = so_oe ? so_o : ~so_o;
      sck = 1'b1;
      repeat (HALF) @(negedge clk_sys);
      sck = 1'b0;
    end
  endtask : xfer

  task automatic send(input logic [7:0] tx);
    logic [7:0] rx;
    xfer(tx, rx);
  endtask : send

  task automatic prefix(input logic [7:0] op);
    select();
    send(8'h3d);
    send(8'h2a);
    send(8'h7f);
    send(op);
  endtask : prefix

  // si is inverted with chip select, so it stops showing the last bit
  task automatic deselect();
    repeat (HALF) @(negedge clk_sys);
    cs_b = 1'b1;
    si   = ~si;
  endtask : deselect
endmodule : spi_host_model

// File: test/sector_protect_lockdown_cmds_tb.sv
// self-checking bench for the protection register and lockdown commands
module sector_protect_lockdown_cmds_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int NCYC  = 1500;
  localparam int LIMIT = 40000;

  logic         clk_sys, rst_b, cs_b, sck, si, so_o, so_oe, busy;
  logic         buf1_clobber, prot_enable, op_locked, op_blocked, clob_seen;
  logic [7:0]   rx, d;
  logic [23:0]  op_addr;
  logic [127:0] protect_map, lock_map, exp_prot, exp_lock;
  logic [7:0]   bad [3] = '{8'hfd, 8'h31, 8'h30};
  logic [23:0]  la [3]  = '{24'h071234, 24'h000a00, 24'h0011ff};
  logic [7:0]   lv [3]  = '{8'hff, 8'hc0, 8'h30};
  int           li [3]  = '{3, 0, 0};
  int           n_errors = 0;
  int           total_checks = 0;
  int           cycles = 0;

  sector_protect_lockdown_cmds #(.PROG_CYCLES(NCYC), .ERASE_CYCLES(NCYC)) dut (
    .clk_sys      (clk_sys),
    .rst_b        (rst_b),
    .cs_b         (cs_b),
    .sck          (sck),
    .si           (si),
    .so_o         (so_o),
    .so_oe        (so_oe),
    .busy         (busy),
    .buf1_clobber (buf1_clobber),
    .prot_enable  (prot_enable),
    .op_addr      (op_addr),
    .op_locked    (op_locked),
    .op_blocked   (op_blocked),
    .protect_map  (protect_map),
    .lock_map     (lock_map)
  );

  spi_host_model host (
    .clk_sys (clk_sys),
    .cs_b    (cs_b),
    .sck     (sck),
    .si      (si),
    .so_o    (so_o),
    .so_oe   (so_oe)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (buf1_clobber === 1'b1)
      clob_seen = 1'b1;
    if (cycles == LIMIT) begin
      n_errors++;
      test_done();
    end
  end

  // ********
  // helpers
  // ********
  task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic busy_up(input string nm);
    int k;
    k = 0;
    while (busy !== 1'b1 && k < 20) begin
      @(negedge clk_sys);
      k++;
    end
    check(nm, 128'(busy), 128'h1);
  endtask : busy_up

  // lo is loose where the cycle was already under way when counting began
  task automatic busy_down(input string nm, input int lo);
    int n;
    n = 0;
    while (busy === 1'b1 && n < 2 * NCYC) begin
      @(negedge clk_sys);
      n++;
    end
    check(nm, 128'(n >= lo && n <= NCYC + 2), 128'h1);
  endtask : busy_down

  task automatic probe(input logic [23:0] a, input logic pe, input logic lk, input logic bl);
    op_addr     = a;
    prot_enable = pe;
    @(negedge clk_sys);
    check("op_locked", 128'(op_locked), 128'(lk));
    check("op_blocked", 128'(op_blocked), 128'(bl));
  endtask : probe

  task automatic erase();
    host.prefix(8'hcf);
    host.deselect();
    busy_up("erase busy");
    busy_down("erase time", NCYC - 2);
  endtask : erase

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // ********
  // tests
  // ********
  initial begin
    rst_b       = 1'b0;
    prot_enable = 1'b0;
    op_addr     = 24'h0;
    clob_seen   = 1'b0;
    exp_prot    = 128'h0;
    exp_lock    = 128'h0;
    repeat (16) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (12) @(negedge clk_sys);
    check("protect_map", protect_map, exp_prot);
    check("lock_map", lock_map, exp_lock);
    check("busy", 128'(busy), 128'h0);
    $display("test reset done");
    erase();
    exp_prot = '1;
    check("protect_map", protect_map, exp_prot);
    probe(24'h040000, 1'b1, 1'b0, 1'b1);
    $display("test erase done");
    // program can only clear bits; the 17th byte lands on sector 0
    host.prefix(8'hfc);
    for (int k = 0; k < 17; k++) begin
      d = (k[0] || k == 16) ? 8'h00 : 8'hff;
      host.send(d);
      exp_prot[8*(k%16) +: 8] &= d;
    end
    check("buf1_clobber", 128'(clob_seen), 128'h1);
    host.deselect();
    busy_up("program busy");
    host.prefix(8'hcf);
    host.deselect();
    busy_down("program time", 1);
    repeat (40) @(negedge clk_sys);
    check("busy", 128'(busy), 128'h0);
    check("protect_map", protect_map, exp_prot);
    probe(24'h040000, 1'b1, 1'b0, 1'b1);
    probe(24'h060000, 1'b1, 1'b0, 1'b0);
    probe(24'h040000, 1'b0, 1'b0, 1'b0);
    $display("test program done");
    host.select();
    host.send(8'h32);
    repeat (3) host.send(8'h5a);
    for (int k = 0; k < 16; k++) begin
      host.xfer(8'h00, rx);
      check("read byte", 128'(rx), 128'(exp_prot[8*k +: 8]));
    end
    check("so_oe", 128'(so_oe), 128'h1);
    host.deselect();
    repeat (8) @(negedge clk_sys);
    check("so_oe", 128'(so_oe), 128'h0);
    $display("test read done");
    foreach (bad[i]) begin
      host.prefix(bad[i]);
      host.send(8'h00);
      host.deselect();
      repeat (40) @(negedge clk_sys);
      check("busy", 128'(busy), 128'h0);
      check("protect_map", protect_map, exp_prot);
      check("lock_map", lock_map, exp_lock);
    end
    $display("test bad opcode done");
    foreach (la[i]) begin
      host.prefix(8'h30);
      host.send(la[i][23:16]);
      host.send(la[i][15:8]);
      host.send(la[i][7:0]);
      host.deselect();
      busy_up("lock busy");
      busy_down("lock time", NCYC - 2);
      exp_lock[8*li[i] +: 8] |= lv[i];
      check("lock_map", lock_map, exp_lock);
      probe(la[i], 1'(i), 1'b1, 1'b1);
    end
    probe(24'h07ffff, 1'b0, 1'b1, 1'b1);
    probe(24'h000e00, 1'b0, 1'b1, 1'b1);
    probe(24'h090000, 1'b0, 1'b0, 1'b0);
    erase();
    check("lock_map", lock_map, exp_lock);
    probe(24'h07ffff, 1'b0, 1'b1, 1'b1);
    $display("test lockdown done");
    test_done();
  end
endmodule : sector_protect_lockdown_cmds_tb
